// [icc_cache.sv]
`timescale 1ns/1ps
module icc_cache
	import icc_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire icc_fetch_s icode_in,
	input wire icc_fetch_s dcode_in,
	input wire logic cache_en_in,
	input wire logic lock_en_in,
	input wire logic lock_start_in,
	input wire logic [ICC_ADDR_W-1:0] lock_base_in,
	input wire logic mem_ack_in,
	input wire logic [ICC_DATA_W-1:0] mem_rdata_in,
	output icc_reply_s icode_out,
	output icc_reply_s dcode_out,
	output logic mem_req_out,
	output logic [ICC_ADDR_W-1:0] mem_addr_out,
	output logic lock_busy_out,
	output logic lock_active_out
);
	logic rst_meta_r;
	logic rst_n_r;
	icc_state_e state_r;
	icc_reply_s icode_r;
	icc_reply_s dcode_r;
	logic mem_req_r;
	logic [ICC_ADDR_W-1:0] mem_addr_r;
	logic lock_busy_r;
	logic lock_active_r;
	logic port_d_r;
	logic prio_d_r;
	logic [ICC_WAY_W-1:0] fill_way_r;
	logic [ICC_OFF_W-1:0] want_off_r;
	logic [ICC_DATA_W-1:0] word_r;

	logic [ICC_DATA_W-1:0] data_mem [ICC_WAYS][ICC_SETS][ICC_LINE_WORDS];
	logic [ICC_TAG_W-1:0] tag_mem [ICC_WAYS][ICC_SETS];
	logic [ICC_WAYS-1:0][ICC_SETS-1:0] valid_r;
	logic [ICC_WAY_W*ICC_WAYS-1:0] lru_mem [ICC_SETS];

	logic i_want;
	logic d_want;
	logic pick_d;
	logic take;
	logic [ICC_ADDR_W-1:0] req_addr;
	logic [ICC_IDX_W-1:0] idx;
	logic [ICC_TAG_W-1:0] tag;
	logic [ICC_OFF_W-1:0] off;
	logic [ICC_WAYS-1:0] hit_vec;
	logic [ICC_WAY_W-1:0] hit_way;
	logic hit_go;
	logic miss_go;
	logic byp_go;
	logic [ICC_IDX_W-1:0] fidx;
	logic [ICC_OFF_W-1:0] fbeat;
	logic last_beat;
	logic filling;
	logic preload_end;
	logic [ICC_IDX_W-1:0] lru_idx;
	logic [ICC_WAY_W-1:0] touch_way;
	logic [ICC_WAY_W*ICC_WAYS-1:0] lru_next;
	logic [ICC_WAY_W-1:0] victim;
	logic [ICC_WAYS-1:0] lock_mask;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// Round-robin between the two code buses, both into one array
	assign i_want = icode_in.req && !icode_r.ack;
	assign d_want = dcode_in.req && !dcode_r.ack;
	assign pick_d = d_want && (!i_want || prio_d_r);
	assign take = (state_r == ICC_IDLE) && !lock_start_in && (i_want || d_want);
	assign req_addr = pick_d ? dcode_in.addr : icode_in.addr;
	assign idx = req_addr[ICC_IDX_LSB +: ICC_IDX_W];
	assign tag = req_addr[ICC_TAG_LSB +: ICC_TAG_W];
	assign off = req_addr[ICC_OFF_LSB +: ICC_OFF_W];

	// Tag lookup over all ways; no address region is excluded
	always_comb begin
		hit_way = '0;
		for (int w = 0; w < ICC_WAYS; w++) begin
			hit_vec[w] = valid_r[w][idx] && (tag_mem[w][idx] == tag);
			if (hit_vec[w]) begin
				hit_way = ICC_WAY_W'(w);
			end
		end
	end

	assign hit_go = take && cache_en_in && (|hit_vec);
	assign miss_go = take && cache_en_in && !(|hit_vec);
	assign byp_go = take && !cache_en_in;

	assign fidx = mem_addr_r[ICC_IDX_LSB +: ICC_IDX_W];
	assign fbeat = mem_addr_r[ICC_OFF_LSB +: ICC_OFF_W];
	assign last_beat = &fbeat;
	assign filling = (state_r == ICC_FILL) || (state_r == ICC_PRELOAD);
	assign preload_end = last_beat && (&fidx);

	assign lru_idx = (state_r == ICC_IDLE) ? idx : fidx;
	assign touch_way = (state_r == ICC_IDLE) ? hit_way : fill_way_r;
	assign lock_mask = lock_active_r ? (ICC_WAYS'(1) << ICC_LOCK_WAY) : '0;

	icc_lru u_lru (
		.ages_in(lru_mem[lru_idx]),
		.touch_in(touch_way),
		.lock_mask_in(lock_mask),
		.ages_out(lru_next),
		.victim_out(victim)
	);

	always_ff @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= ICC_IDLE;
			icode_r <= '0;
			dcode_r <= '0;
			mem_req_r <= 1'b0;
			mem_addr_r <= '0;
			lock_busy_r <= 1'b0;
			port_d_r <= 1'b0;
			prio_d_r <= 1'b0;
			fill_way_r <= '0;
			want_off_r <= '0;
			word_r <= '0;
		end else begin
			icode_r.ack <= 1'b0;
			dcode_r.ack <= 1'b0;
			unique case (state_r)
				ICC_IDLE: begin
					if (lock_start_in && lock_en_in && cache_en_in) begin
						state_r <= ICC_PRELOAD;
						lock_busy_r <= 1'b1;
						fill_way_r <= ICC_LOCK_WAY;
						mem_req_r <= 1'b1;
						mem_addr_r <= {lock_base_in[ICC_ADDR_W-1:ICC_TAG_LSB], {ICC_TAG_LSB{1'b0}}};
					end else if (take) begin
						prio_d_r <= !pick_d;
						port_d_r <= pick_d;
						if (hit_go) begin
							if (pick_d) begin
								dcode_r.ack <= 1'b1;
								dcode_r.data <= data_mem[hit_way][idx][off];
							end else begin
								icode_r.ack <= 1'b1;
								icode_r.data <= data_mem[hit_way][idx][off];
							end
						end else if (miss_go) begin
							state_r <= ICC_FILL;
							fill_way_r <= victim;
							want_off_r <= off;
							mem_req_r <= 1'b1;
							mem_addr_r <= {req_addr[ICC_ADDR_W-1:ICC_IDX_LSB], {ICC_IDX_LSB{1'b0}}};
						end else begin
							state_r <= ICC_BYPASS;
							mem_req_r <= 1'b1;
							mem_addr_r <= {req_addr[ICC_ADDR_W-1:ICC_OFF_LSB], {ICC_OFF_LSB{1'b0}}};
						end
					end
				end
				ICC_FILL, ICC_PRELOAD: begin
					if (mem_ack_in) begin
						mem_addr_r <= mem_addr_r + ICC_WORD_STEP;
						if (fbeat == want_off_r) begin
							word_r <= mem_rdata_in;
						end
						if (state_r == ICC_FILL && last_beat) begin
							state_r <= ICC_IDLE;
							mem_req_r <= 1'b0;
							if (port_d_r) begin
								dcode_r.ack <= 1'b1;
								dcode_r.data <= (fbeat == want_off_r) ? mem_rdata_in : word_r;
							end else begin
								icode_r.ack <= 1'b1;
								icode_r.data <= (fbeat == want_off_r) ? mem_rdata_in : word_r;
							end
						end else if (state_r == ICC_PRELOAD && preload_end) begin
							state_r <= ICC_IDLE;
							mem_req_r <= 1'b0;
							lock_busy_r <= 1'b0;
						end
					end
				end
				ICC_BYPASS: begin
					if (mem_ack_in) begin
						state_r <= ICC_IDLE;
						mem_req_r <= 1'b0;
						if (port_d_r) begin
							dcode_r.ack <= 1'b1;
							dcode_r.data <= mem_rdata_in;
						end else begin
							icode_r.ack <= 1'b1;
							icode_r.data <= mem_rdata_in;
						end
					end
				end
				default: begin
					state_r <= ICC_IDLE;
					mem_req_r <= 1'b0;
					lock_busy_r <= 1'b0;
				end
			endcase
		end
	end

	// Lock stays in force until software drops the lock enable
	always_ff @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			lock_active_r <= 1'b0;
		end else if (!lock_en_in) begin
			lock_active_r <= 1'b0;
		end else if (state_r == ICC_PRELOAD && mem_ack_in && preload_end) begin
			lock_active_r <= 1'b1;
		end
	end

	// Line storage, written only by fills and preload
	always_ff @(posedge clk_in) begin
		if (filling && mem_ack_in) begin
			data_mem[fill_way_r][fidx][fbeat] <= mem_rdata_in;
			if (last_beat) begin
				tag_mem[fill_way_r][fidx] <= mem_addr_r[ICC_TAG_LSB +: ICC_TAG_W];
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			valid_r <= '0;
		end else if (filling && mem_ack_in && last_beat) begin
			valid_r[fill_way_r][fidx] <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			for (int s = 0; s < ICC_SETS; s++) begin
				lru_mem[s] <= ICC_LRU_RESET;
			end
		end else if (hit_go || (filling && mem_ack_in && last_beat)) begin
			lru_mem[lru_idx] <= lru_next;
		end
	end

	assign icode_out = icode_r;
	assign dcode_out = dcode_r;
	assign mem_req_out = mem_req_r;
	assign mem_addr_out = mem_addr_r;
	assign lock_busy_out = lock_busy_r;
	assign lock_active_out = lock_active_r;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_r);

	property p_one_way;
		take |-> $onehot0(hit_vec);
	endproperty
	a_one_way: assert property (p_one_way) else $error("line present in two ways");

	property p_hit_zero_wait;
		hit_go |=> (icode_r.ack || dcode_r.ack) && state_r == ICC_IDLE;
	endproperty
	a_hit_zero_wait: assert property (p_hit_zero_wait) else $error("hit not answered next cycle");

	property p_shared;
		!(icode_r.ack && dcode_r.ack);
	endproperty
	a_shared: assert property (p_shared) else $error("both buses answered together");

	property p_miss_fill;
		miss_go |=> state_r == ICC_FILL && mem_req_out && fbeat == '0;
	endproperty
	a_miss_fill: assert property (p_miss_fill) else $error("miss did not start line fill");

	property p_miss_addr;
		miss_go |=> mem_addr_out[ICC_ADDR_W-1:ICC_IDX_LSB] == $past(req_addr[ICC_ADDR_W-1:ICC_IDX_LSB]);
	endproperty
	a_miss_addr: assert property (p_miss_addr) else $error("fill fetched wrong line");

	property p_lock_load;
		(state_r == ICC_PRELOAD && mem_ack_in && preload_end && lock_en_in)
			|=> lock_active_r && state_r == ICC_IDLE && !lock_busy_out;
	endproperty
	a_lock_load: assert property (p_lock_load) else $error("lock not in force after preload");

	property p_lock_victim;
		(miss_go && lock_active_r) |=> fill_way_r != ICC_LOCK_WAY;
	endproperty
	a_lock_victim: assert property (p_lock_victim) else $error("locked way chosen as victim");

	property p_off_bypass;
		byp_go |=> state_r == ICC_BYPASS && mem_req_out;
	endproperty
	a_off_bypass: assert property (p_off_bypass) else $error("disabled fetch not sent to memory");

	property p_off_noalloc;
		state_r == ICC_BYPASS |=> $stable(valid_r);
	endproperty
	a_off_noalloc: assert property (p_off_noalloc) else $error("disabled fetch allocated a line");
endmodule

// [icc_pkg.sv]
// Contract
// - Cache holds 8 Kbyte of code as a 4-way set associative array.
// - A fetch that hits is answered with no wait states.
// - One array serves both the instruction and the data code bus.
// - A miss fills the line from memory, evicting the least recently used way.
// - Code from external DDR or on-chip non-volatile store is cached alike.
// - Locked mode loads a fixed code segment into the cache and holds it.
// - While locked, the locked lines are never chosen as victims.
// - The cache can be switched off; then every fetch goes to memory.
// - Processor fetches from the on-chip non-volatile store are cacheable.
package icc_pkg;
	localparam int ICC_CACHE_BYTES = 8192;
	localparam int ICC_WAYS = 4;
	localparam int ICC_LINE_WORDS = 4;
	localparam int ICC_WORD_BYTES = 4;
	localparam int ICC_SETS = ICC_CACHE_BYTES / (ICC_WAYS * ICC_LINE_WORDS * ICC_WORD_BYTES);
	localparam int ICC_ADDR_W = 32;
	localparam int ICC_DATA_W = 32;
	localparam int ICC_WAY_W = $clog2(ICC_WAYS);
	localparam int ICC_OFF_LSB = $clog2(ICC_WORD_BYTES);
	localparam int ICC_OFF_W = $clog2(ICC_LINE_WORDS);
	localparam int ICC_IDX_LSB = ICC_OFF_LSB + ICC_OFF_W;
	localparam int ICC_IDX_W = $clog2(ICC_SETS);
	localparam int ICC_TAG_LSB = ICC_IDX_LSB + ICC_IDX_W;
	localparam int ICC_TAG_W = ICC_ADDR_W - ICC_TAG_LSB;
	localparam logic [ICC_WAY_W-1:0] ICC_LOCK_WAY = 2'h0;
	localparam logic [ICC_ADDR_W-1:0] ICC_WORD_STEP = 32'h0000_0004;
	// Way w starts with age w, 0 being most recent
	localparam logic [2*ICC_WAYS-1:0] ICC_LRU_RESET = 8'he4;

	typedef enum logic [2:0] {
		ICC_IDLE = 3'b000,
		ICC_FILL = 3'b001,
		ICC_BYPASS = 3'b010,
		ICC_PRELOAD = 3'b011
	} icc_state_e;

	typedef struct packed {
		logic req;
		logic [ICC_ADDR_W-1:0] addr;
	} icc_fetch_s;

	typedef struct packed {
		logic ack;
		logic [ICC_DATA_W-1:0] data;
	} icc_reply_s;
endpackage

// [icc_lru.sv]
`timescale 1ns/1ps
module icc_lru
	import icc_pkg::*;
(
	input wire logic [ICC_WAY_W*ICC_WAYS-1:0] ages_in,
	input wire logic [ICC_WAY_W-1:0] touch_in,
	input wire logic [ICC_WAYS-1:0] lock_mask_in,
	output logic [ICC_WAY_W*ICC_WAYS-1:0] ages_out,
	output logic [ICC_WAY_W-1:0] victim_out
);
	logic [ICC_WAY_W-1:0] touch_age;
	logic [ICC_WAY_W-1:0] best_age;
	logic found;

	assign touch_age = ages_in[touch_in*ICC_WAY_W +: ICC_WAY_W];

	// Touched way becomes youngest, younger ones age by one
	always_comb begin
		for (int w = 0; w < ICC_WAYS; w++) begin
			if (ICC_WAY_W'(w) == touch_in) begin
				ages_out[w*ICC_WAY_W +: ICC_WAY_W] = '0;
			end else if (ages_in[w*ICC_WAY_W +: ICC_WAY_W] < touch_age) begin
				ages_out[w*ICC_WAY_W +: ICC_WAY_W] = ages_in[w*ICC_WAY_W +: ICC_WAY_W] + 1'b1;
			end else begin
				ages_out[w*ICC_WAY_W +: ICC_WAY_W] = ages_in[w*ICC_WAY_W +: ICC_WAY_W];
			end
		end
	end

	// Oldest way that is not locked
	always_comb begin
		victim_out = '0;
		best_age = '0;
		found = 1'b0;
		for (int w = 0; w < ICC_WAYS; w++) begin
			if (!lock_mask_in[w] && (!found || ages_in[w*ICC_WAY_W +: ICC_WAY_W] >= best_age)) begin
				victim_out = ICC_WAY_W'(w);
				best_age = ages_in[w*ICC_WAY_W +: ICC_WAY_W];
				found = 1'b1;
			end
		end
	end
endmodule

// [icc_mem_model.sv]
`timescale 1ns/1ps
module icc_mem_model
	import icc_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic mem_req_in,
	input wire logic [ICC_ADDR_W-1:0] mem_addr_in,
	input wire logic slow_in,
	output logic mem_ack_out,
	output logic [ICC_DATA_W-1:0] mem_rdata_out
);
	logic [1:0] wait_r;

	// Any address answers alike, near or far memory
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mem_ack_out <= 1'b0;
			mem_rdata_out <= 32'h0;
			wait_r <= 2'h0;
		end else if (mem_req_in && !mem_ack_out && (!slow_in || wait_r == 2'h3)) begin
			mem_ack_out <= 1'b1;
			mem_rdata_out <= ~mem_addr_in;
			wait_r <= 2'h0;
		end else begin
			mem_ack_out <= 1'b0;
			// Stale data never looks valid
			mem_rdata_out <= ~mem_rdata_out;
			if (mem_req_in && !mem_ack_out)
				wait_r <= wait_r + 2'h1;
		end
	end
endmodule

// [icc_cache_test.sv]
`timescale 1ns/1ps
module icc_cache_test
	import icc_pkg::*;
;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	icc_fetch_s icode_in = '0;
	icc_fetch_s dcode_in = '0;
	logic cache_en_in = 1'b1;
	logic lock_en_in = 1'b0;
	logic lock_start_in = 1'b0;
	logic [31:0] lock_base_in = 32'h0;
	logic mem_ack_in;
	logic [31:0] mem_rdata_in;
	icc_reply_s icode_out;
	icc_reply_s dcode_out;
	logic mem_req_out;
	logic [31:0] mem_addr_out;
	logic lock_busy_out;
	logic lock_active_out;
	logic slow = 1'b0;
	logic order_ok = 1'b1;
	logic [31:0] first_addr = 32'h0;
	int failures = 0;
	int checks_done = 0;
	int beats = 0;

	icc_cache dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .icode_in(icode_in),
		.dcode_in(dcode_in), .cache_en_in(cache_en_in), .lock_en_in(lock_en_in),
		.lock_start_in(lock_start_in), .lock_base_in(lock_base_in), .mem_ack_in(mem_ack_in),
		.mem_rdata_in(mem_rdata_in), .icode_out(icode_out), .dcode_out(dcode_out),
		.mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
		.lock_busy_out(lock_busy_out), .lock_active_out(lock_active_out));
	icc_mem_model mem_u (.clk_in(clk_in), .resetn_in(resetn_in), .mem_req_in(mem_req_out),
		.mem_addr_in(mem_addr_out), .slow_in(slow), .mem_ack_out(mem_ack_in),
		.mem_rdata_out(mem_rdata_in));

	always #5 clk_in = ~clk_in;

	// Count memory beats and watch their address order
	always @(posedge clk_in) begin
		if (mem_req_out === 1'b1 && mem_ack_in === 1'b1) begin
			if (beats == 0)
				first_addr <= mem_addr_out;
			else if (mem_addr_out !== first_addr + 32'(4 * beats))
				order_ok <= 1'b0;
			beats <= beats + 1;
		end
	end

	task give_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic fetch(input bit port, input logic [31:0] a, input int exp_beats);
		int n;
		icc_reply_s r;
		@(posedge clk_in);
		beats = 0;
		order_ok = 1'b1;
		if (port)
			dcode_in <= '{req: 1'b1, addr: a};
		else
			icode_in <= '{req: 1'b1, addr: a};
		n = 0;
		r = '0;
		while (r.ack !== 1'b1) begin
			@(posedge clk_in);
			n++;
			r = port ? dcode_out : icode_out;
			if (n > 60) begin
				failures++;
				$display("[ERR] %0t fetch answer missing", $time);
				give_verdict();
			end
		end
		icode_in <= '0;
		dcode_in <= '0;
		check(r.data, ~a);
		check(32'(beats), 32'(exp_beats));
		if (exp_beats == 0)
			check(32'(n), 32'h2);
		if (exp_beats == 1)
			check(first_addr, a);
		if (exp_beats == 4) begin
			check(first_addr, {a[31:4], 4'h0});
			check({31'h0, order_ok}, 32'h1);
		end
	endtask

	task automatic sc_fill_hit;
		fetch(1'b0, 32'h6000_0104, 4);
		fetch(1'b0, 32'h6000_0108, 0);
		fetch(1'b1, 32'h6000_010c, 0);
		fetch(1'b1, 32'h0000_2200, 4);
		fetch(1'b0, 32'h0000_2204, 0);
	endtask

	// Both buses at once; data bus holds the next turn
	task automatic sc_both;
		int n;
		int d_at;
		int i_at;
		@(posedge clk_in);
		icode_in <= '{req: 1'b1, addr: 32'h6000_0104};
		dcode_in <= '{req: 1'b1, addr: 32'h0000_2208};
		n = 0;
		d_at = 0;
		i_at = 0;
		while (d_at == 0 || i_at == 0) begin
			@(posedge clk_in);
			n++;
			if (dcode_out.ack === 1'b1 && d_at == 0) begin
				d_at = n;
				dcode_in <= '0;
				check(dcode_out.data, ~32'h0000_2208);
			end
			if (icode_out.ack === 1'b1 && i_at == 0) begin
				i_at = n;
				icode_in <= '0;
				check(icode_out.data, ~32'h6000_0104);
			end
			if (n > 20) begin
				failures++;
				$display("[ERR] %0t shared answer missing", $time);
				give_verdict();
			end
		end
		check(32'(d_at), 32'h2);
		check(32'(i_at), 32'h3);
	endtask

	task automatic sc_lru;
		slow <= 1'b1;
		for (int k = 0; k < 4; k++)
			fetch(k[0], 32'h40 + 32'(k) * 32'h800, 4);
		fetch(1'b0, 32'h0000_0040, 0);
		fetch(1'b1, 32'h0000_2040, 4);
		fetch(1'b0, 32'h0000_0040, 0);
		fetch(1'b1, 32'h0000_0840, 4);
		fetch(1'b0, 32'h0000_1840, 0);
		slow <= 1'b0;
	endtask

	task automatic sc_disable;
		cache_en_in <= 1'b0;
		fetch(1'b0, 32'h0000_0040, 1);
		fetch(1'b1, 32'h0000_3300, 1);
		fetch(1'b1, 32'h0000_3300, 1);
		cache_en_in <= 1'b1;
		fetch(1'b0, 32'h0000_3300, 4);
		fetch(1'b0, 32'h0000_0040, 0);
	endtask

	task automatic sc_lock;
		int n;
		@(posedge clk_in);
		lock_en_in <= 1'b1;
		lock_base_in <= 32'h0010_0123;
		beats = 0;
		order_ok = 1'b1;
		@(posedge clk_in);
		lock_start_in <= 1'b1;
		@(posedge clk_in);
		lock_start_in <= 1'b0;
		n = 0;
		while (lock_active_out !== 1'b1) begin
			@(posedge clk_in);
			n++;
			if (n == 1)
				check({31'h0, lock_busy_out}, 32'h1);
			if (n > 3000) begin
				failures++;
				$display("[ERR] %0t preload never finished", $time);
				give_verdict();
			end
		end
		check(32'(beats), 32'd512);
		check(first_addr, 32'h0010_0000);
		check({31'h0, order_ok}, 32'h1);
		check({31'h0, lock_busy_out}, 32'h0);
		fetch(1'b0, 32'h0010_0040, 0);
		for (int k = 1; k < 5; k++)
			fetch(k[0], 32'h0020_0040 + 32'(k) * 32'h800, 4);
		fetch(1'b1, 32'h0010_0040, 0);
	endtask

	initial begin
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		sc_fill_hit();
		sc_both();
		sc_lru();
		sc_disable();
		sc_lock();
		give_verdict();
	end
endmodule
